/* File: core/spoe_cfg.svh */
// Constants for the serial-to-parallel output expander
`ifndef SPOE_CFG_SVH
`define SPOE_CFG_SVH
`define SPOE_WIDTH 12
`define SPOE_RST_BIT 1'b0
`define SPOE_RST_WORD 12'h000
`define SPOE_CLK_HALF 5'h0a
`define SPOE_STB_HOLD 5'h04
`define SPOE_IDLE_LOW 1'b0
`define SPOE_IDLE_HIGH 1'b1
`endif

/* File: core/spoe_dev.sv */
// Expander end: shift register, output latch, chain output
`timescale 1ns/10ps
`include "spoe_cfg.svh"
module spoe_dev (
  // System
  input wire logic REF_CLK,
  input wire logic RST_B,
  // Link
  spoe_link_if.dev LINK,
  // Parallel side
  output spoe_pkg::spoe_word_t PARALLEL_OUTPUTS
);

  // Two-stage synchronisers for the four link inputs, plus the clock history
  logic sclk_meta_ff;
  logic sclk_sync_ff;
  logic sclk_prev_ff;
  logic sdata_meta_ff;
  logic sdata_sync_ff;
  logic stb_meta_ff;
  logic stb_sync_ff;
  logic clr_meta_ff;
  logic clr_sync_ff;

  // Core storage
  spoe_pkg::spoe_word_t shift_ff;
  spoe_pkg::spoe_word_t latch_ff;
  logic sout_ff;

  // Decoded conditions and next values
  wire sclk_rise;
  wire stb_low;
  wire clr_low;
  wire follow_reg;
  spoe_pkg::spoe_word_t nxt_shift;
  spoe_pkg::spoe_word_t nxt_latch;
  logic nxt_sout;

  // Move every stage one step toward the end, new bit into stage one
  function automatic spoe_pkg::spoe_word_t shift_one(
    input spoe_pkg::spoe_word_t cur,
    input logic din
  );
    shift_one = {cur[`SPOE_WIDTH-2:0], din};
  endfunction : shift_one

  // True when a synchronised level went from low to high
  function automatic logic rose_between(
    input logic prev,
    input logic cur
  );
    rose_between = cur & ~prev;
  endfunction : rose_between

  // Clear wins over strobe; without either the latch holds
  function automatic spoe_pkg::spoe_word_t latch_next(
    input logic clr_on,
    input logic follow,
    input spoe_pkg::spoe_word_t reg_word,
    input spoe_pkg::spoe_word_t held
  );
    latch_next = held;
    if (follow) begin
      latch_next = reg_word;
    end
    if (clr_on) begin
      latch_next = `SPOE_RST_WORD;
    end
  endfunction : latch_next

  // Edge detect reads only the second and third stages
  assign sclk_rise = rose_between(sclk_prev_ff, sclk_sync_ff);
  assign stb_low = ~stb_sync_ff;
  assign clr_low = ~clr_sync_ff;

  // Strobe low makes the latch transparent unless clear is active
  assign follow_reg = stb_low & ~clr_low;

  // Bit 0 is stage one; first bit in reaches bit 11 after twelve clocks
  assign nxt_shift = sclk_rise ? shift_one(shift_ff, sdata_sync_ff) : shift_ff;
  assign nxt_latch = latch_next(clr_low, follow_reg, nxt_shift, latch_ff);
  assign nxt_sout = nxt_shift[`SPOE_WIDTH-1];

  // Outputs come straight from flip-flops
  assign LINK.sout = sout_ff;
  assign PARALLEL_OUTPUTS = latch_ff;

  // Shift clock, first stage
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      sclk_meta_ff <= `SPOE_IDLE_LOW;
    end else begin
      sclk_meta_ff <= LINK.sclk;
    end
  end

  // Shift clock, second stage
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      sclk_sync_ff <= `SPOE_IDLE_LOW;
    end else begin
      sclk_sync_ff <= sclk_meta_ff;
    end
  end

  // Shift clock, previous synchronised level
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      sclk_prev_ff <= `SPOE_IDLE_LOW;
    end else begin
      sclk_prev_ff <= sclk_sync_ff;
    end
  end

  // Serial data, first stage
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      sdata_meta_ff <= `SPOE_IDLE_LOW;
    end else begin
      sdata_meta_ff <= LINK.sdata;
    end
  end

  // Serial data, second stage
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      sdata_sync_ff <= `SPOE_IDLE_LOW;
    end else begin
      sdata_sync_ff <= sdata_meta_ff;
    end
  end

  // Strobe, first stage; idles high so reset gives no false load
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      stb_meta_ff <= `SPOE_IDLE_HIGH;
    end else begin
      stb_meta_ff <= LINK.latch_strobe_n;
    end
  end

  // Strobe, second stage
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      stb_sync_ff <= `SPOE_IDLE_HIGH;
    end else begin
      stb_sync_ff <= stb_meta_ff;
    end
  end

  // Clear, first stage; idles high so reset gives no false clear
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      clr_meta_ff <= `SPOE_IDLE_HIGH;
    end else begin
      clr_meta_ff <= LINK.output_clear_n;
    end
  end

  // Clear, second stage
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      clr_sync_ff <= `SPOE_IDLE_HIGH;
    end else begin
      clr_sync_ff <= clr_meta_ff;
    end
  end

  // Shift register has no clear term at all
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      shift_ff <= `SPOE_RST_WORD;
    end else begin
      shift_ff <= nxt_shift;
    end
  end

  // Output latch
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      latch_ff <= `SPOE_RST_WORD;
    end else begin
      latch_ff <= nxt_latch;
    end
  end

  // Chain output, updated on the same edge as the shift
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      sout_ff <= `SPOE_RST_BIT;
    end else begin
      sout_ff <= nxt_sout;
    end
  end
endmodule : spoe_dev

/* File: core/spoe_host.sv */
// Host end: shifts a word out, then pulses the strobe
`timescale 1ns/10ps
`include "spoe_cfg.svh"
module spoe_host (
  // System
  input wire logic REF_CLK,
  input wire logic RST_B,
  // User request
  input wire logic SEND,
  input spoe_pkg::spoe_word_t WORD,
  input wire logic CLEAR_REQ,
  output logic BUSY,
  output logic CHAIN_IN,
  // Link
  spoe_link_if.host LINK
);
  spoe_pkg::spoe_state_e state_ff;
  spoe_pkg::spoe_state_e nxt_state;
  spoe_pkg::spoe_word_t data_ff;
  logic [3:0] bit_ff;
  logic [4:0] tick_ff;
  logic sclk_ff;
  logic sdata_ff;
  logic stb_n_ff;
  logic clr_n_ff;
  logic busy_ff;
  logic [1:0] sout_sync_ff;
  wire tick_done;
  wire last_bit;
  wire start;
  // Half period of 10 cycles gives 5 MHz at most
  assign tick_done = tick_ff == (`SPOE_CLK_HALF - 5'h01);
  assign last_bit = bit_ff == 4'(`SPOE_WIDTH - 1);
  assign start = SEND & ~busy_ff;
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      spoe_pkg::SPOE_IDLE: if (start) nxt_state = spoe_pkg::SPOE_LOW;
      spoe_pkg::SPOE_LOW: if (tick_done) nxt_state = spoe_pkg::SPOE_HIGH;
      spoe_pkg::SPOE_HIGH: if (tick_done) begin
        nxt_state = last_bit ? spoe_pkg::SPOE_STB : spoe_pkg::SPOE_LOW;
      end
      spoe_pkg::SPOE_STB: if (tick_ff == `SPOE_STB_HOLD) nxt_state = spoe_pkg::SPOE_DONE;
      spoe_pkg::SPOE_DONE: nxt_state = spoe_pkg::SPOE_IDLE;
      default: nxt_state = spoe_pkg::SPOE_IDLE;
    endcase
  end
  assign LINK.sclk = sclk_ff;
  assign LINK.sdata = sdata_ff;
  assign LINK.latch_strobe_n = stb_n_ff;
  assign LINK.output_clear_n = clr_n_ff;
  assign BUSY = busy_ff;
  assign CHAIN_IN = sout_sync_ff[1];
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_ff <= spoe_pkg::SPOE_IDLE;
      data_ff <= `SPOE_RST_WORD;
      bit_ff <= 4'h0;
      tick_ff <= 5'h00;
      sout_sync_ff <= 2'h0;
    end else begin
      state_ff <= nxt_state;
      sout_sync_ff <= {sout_sync_ff[0], LINK.sout};
      tick_ff <= (nxt_state != state_ff) ? 5'h00 : tick_ff + 5'h01;
      if (start) begin
        data_ff <= WORD;
        bit_ff <= 4'h0;
      end else if (state_ff == spoe_pkg::SPOE_HIGH && tick_done) begin
        data_ff <= {data_ff[`SPOE_WIDTH-2:0], 1'b0};
        bit_ff <= bit_ff + 4'h1;
      end
    end
  end
  // MSB goes first so WORD[11] lands on output twelve
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      sclk_ff <= 1'b0;
      sdata_ff <= 1'b0;
      stb_n_ff <= 1'b1;
      clr_n_ff <= 1'b1;
      busy_ff <= 1'b0;
    end else begin
      sclk_ff <= nxt_state == spoe_pkg::SPOE_HIGH;
      sdata_ff <= data_ff[`SPOE_WIDTH-1];
      stb_n_ff <= nxt_state != spoe_pkg::SPOE_STB;
      clr_n_ff <= ~CLEAR_REQ;
      busy_ff <= nxt_state != spoe_pkg::SPOE_IDLE;
    end
  end
endmodule : spoe_host

/* File: core/spoe_link_if.sv */
// Four-wire link between host and expander, plus the chain output
`timescale 1ns/10ps
interface spoe_link_if;
  logic sdata;
  logic sclk;
  logic latch_strobe_n;
  logic output_clear_n;
  logic sout;
  modport dev (input sdata, input sclk, input latch_strobe_n, input output_clear_n,
    output sout);
  modport host (output sdata, output sclk, output latch_strobe_n, output output_clear_n,
    input sout);
endinterface : spoe_link_if

/* File: core/spoe_pkg.sv */
// Types for the serial-to-parallel output expander
`include "spoe_cfg.svh"
package spoe_pkg;
  typedef logic [`SPOE_WIDTH-1:0] spoe_word_t;
  typedef enum logic [2:0] {
    SPOE_IDLE = 3'h0,
    SPOE_LOW = 3'h1,
    SPOE_HIGH = 3'h3,
    SPOE_STB = 3'h2,
    SPOE_DONE = 3'h6
  } spoe_state_e;
endpackage : spoe_pkg

/* File: dv/spoe_link_monitor.sv */
// Protocol checks on the host-to-expander link
`timescale 1ns/10ps
module spoe_link_monitor (
  // System
  input logic REF_CLK,
  input logic RST_B,
  // Link
  input logic sdata,
  input logic sclk,
  input logic latch_strobe_n,
  input logic output_clear_n,
  input logic sout
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  sequence stb_pulse_s;
    !latch_strobe_n [*5] ##1 latch_strobe_n;
  endsequence
  stb_clk_idle_a: assert property (!latch_strobe_n |-> !sclk)
    else $error("clock high under strobe");
  clk_high_min_a: assert property ($rose(sclk) |-> sclk [*8])
    else $error("clock high too short");
  clk_low_min_a: assert property ($fell(sclk) |-> !sclk [*8])
    else $error("clock low too short");
  stb_pulse_a: assert property ($fell(latch_strobe_n) |-> stb_pulse_s)
    else $error("strobe pulse length wrong");
  sout_on_clk_a: assert property ($changed(sout) |-> sclk)
    else $error("chain out moved without clock");
  data_hold_a: assert property (sclk |-> $stable(sdata))
    else $error("data moved while clock high");
  sout_stb_a: assert property (!latch_strobe_n |-> $stable(sout))
    else $error("chain out moved under strobe");
  sout_clr_a: assert property (!output_clear_n |-> $stable(sout))
    else $error("chain out moved under clear");
endmodule : spoe_link_monitor

/* File: dv/spoe_tb_top.sv */
// Testbench: host and expander ends joined over the link
`timescale 1ns/10ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR %s exp %h got %h", nm, e, g); end end
module spoe_tb_top;
  logic REF_CLK = 1'b0;
  logic RST_B = 1'b0;
  logic send = 1'b0;
  logic clear_req = 1'b0;
  logic busy;
  logic chain_in;
  spoe_pkg::spoe_word_t word = 12'h000;
  spoe_pkg::spoe_word_t pout;
  int n_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  spoe_link_if link ();
  spoe_host i_spoe_host (.REF_CLK(REF_CLK), .RST_B(RST_B), .SEND(send), .WORD(word),
    .CLEAR_REQ(clear_req), .BUSY(busy), .CHAIN_IN(chain_in), .LINK(link.host));
  spoe_dev i_spoe_dev (.REF_CLK(REF_CLK), .RST_B(RST_B), .LINK(link.dev),
    .PARALLEL_OUTPUTS(pout));
  spoe_link_monitor i_spoe_link_monitor (.REF_CLK(REF_CLK), .RST_B(RST_B),
    .sdata(link.sdata), .sclk(link.sclk), .latch_strobe_n(link.latch_strobe_n),
    .output_clear_n(link.output_clear_n), .sout(link.sout));
  task automatic wrap_up();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  // Send one word; outputs must hold the old word until the strobe
  task automatic push(input spoe_pkg::spoe_word_t w, input spoe_pkg::spoe_word_t old);
    int i;
    @(posedge REF_CLK);
    word <= w;
    send <= 1'b1;
    @(posedge REF_CLK);
    send <= 1'b0;
    repeat (200) @(posedge REF_CLK);
    `CHK("held", old, pout)
    `CHK("busy", 1'b1, busy)
    for (i = 0; i < 400 && busy !== 1'b0; i++) @(posedge REF_CLK);
    repeat (4) @(posedge REF_CLK);
    `CHK("latched", w, pout)
    `CHK("chain", w[11], chain_in)
    `CHK("idle", 1'b0, busy)
    $display("push %h done", w);
  endtask : push
  initial begin
    forever #5 REF_CLK = ~REF_CLK;
  end
  always @(posedge REF_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      wrap_up();
    end
  end
  initial begin
    repeat (2) @(posedge REF_CLK);
    RST_B <= 1'b1;
    `CHK("reset", 12'h000, pout)
    push(12'ha5c, 12'h000);
    push(12'h3c3, 12'ha5c);
    push(12'hfff, 12'h3c3);
    push(12'h801, 12'hfff);
    clear_req <= 1'b1;
    repeat (6) @(posedge REF_CLK);
    `CHK("cleared", 12'h000, pout)
    clear_req <= 1'b0;
    repeat (6) @(posedge REF_CLK);
    `CHK("stays_clear", 12'h000, pout)
    `CHK("chain_kept", 1'b1, chain_in)
    $display("clear done");
    push(12'h5a5, 12'h000);
    push(12'h000, 12'h5a5);
    wrap_up();
  end
endmodule : spoe_tb_top
